// *** hdl/fspu_status_protect.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Status registers and write protection of a serial NOR flash
// How it works
// - Byte one: lock0, five protect bits, latch and busy flags read-only.
// - Byte two: suspend flags read-only, invert, three lock bits, quad, lock1.
// - Byte three: pin-function select, strength, dummy config; bits 4..2 reserved.
// - Busy flag is one exactly while a program, erase or status write runs.
// - With the latch clear, status writes, programs and erases are refused.
// - Protect bits change only by status write, never under hardware protection.
// - Program and small wipes into the protected range are refused.
// - Whole-array wipe needs low bits 000 uninverted or 111 inverted.
// - Invert set protects the complement of the normal range.
// - Lock bits 00: status writes need only the latch.
// - Lock bits 01: status writes blocked while the protect pin is low and quad is off.
// - Lock bits 10: status writes blocked until power returns them to 00.
// - Lock bits 11: status writes refused until power returns them to 00.
// - Quad enable turns the protect and hold pins into data lines.
// - Security lock bits start clear and, once set, stay set until power-up reset.
// - Latch set by command; cleared by reset, clear, status write, program, erase.
// - Pin low in hardware mode with quad off keeps protect and lock bits unchanged.
// - Without invert, the code selects an upper or lower protected range.
// - Suspend sets the matching suspend flag; resume and resets clear both.
module fspu_status_protect
  import fspu_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic              i_cmd_valid,
  input  wire logic [3:0]        i_cmd_code,
  input  wire logic [ADDR_W-1:0] i_cmd_addr,
  input  wire logic [15:0]       i_cmd_data,
  input  wire logic              i_write_protect_n,
  input  wire logic              i_op_done,
  output logic [7:0]             o_status_low,
  output logic [7:0]             o_status_mid,
  output logic [7:0]             o_status_high,
  output logic                   o_cmd_accepted,
  output logic                   o_cmd_refused,
  output logic                   o_op_start,
  output logic [1:0]             o_op_kind,
  output logic [ADDR_W-1:0]      o_op_addr,
  output logic                   o_op_suspend,
  output logic                   o_op_resume,
  output logic                   o_op_abort,
  output logic                   o_quad_pins
);

  // ========================================================================
  // Storage
  logic [7:0]        sr1_reg, sr1_next;
  logic [7:0]        sr2_reg, sr2_next;
  logic [7:0]        sr3_reg, sr3_next;
  fspu_state_t       state_reg, state_next;
  fspu_op_t          kind_reg, kind_next;
  logic              accepted_reg, refused_reg, start_reg, suspend_reg;
  logic              resume_reg, abort_reg;
  logic [ADDR_W-1:0] addr_reg;

  // Modifying commands share the latch and busy checks
  function automatic logic is_modify(input fspu_cmd_t c);
    return c inside {FSPU_CMD_STATUS_WRITE_12, FSPU_CMD_STATUS_WRITE_3,
                     FSPU_CMD_PAGE_PROGRAM, FSPU_CMD_FOUR_KB_WIPE,
                     FSPU_CMD_BLOCK_WIPE, FSPU_CMD_WHOLE_ARRAY_WIPE};
  endfunction

  // Status writes are the only ones that load the registers from the command data
  function automatic logic is_status_write(input fspu_cmd_t c);
    return c inside {FSPU_CMD_STATUS_WRITE_12, FSPU_CMD_STATUS_WRITE_3};
  endfunction

  // ========================================================================
  // Decoding of the current command and register fields
  wire fspu_cmd_t  cmd       = fspu_cmd_t'(i_cmd_code);
  wire logic       write_enable_latch       = sr1_reg[SR1_WEL];
  wire logic [1:0] lock      = {sr2_reg[SR2_LOCK1], sr1_reg[SR1_LOCK0]};
  wire logic [4:0] bp        = sr1_reg[SR1_BP_HI:SR1_BP_LO];
  wire logic       invert    = sr2_reg[SR2_INVERT];
  wire logic       idle      = (state_reg == FSPU_ST_IDLE);
  wire logic       busy      = (state_reg == FSPU_ST_BUSY);
  wire logic       suspended = (state_reg == FSPU_ST_SUSPENDED);
  // Pin carries data in quad mode, so it no longer protects
  wire logic       wp_low    = !i_write_protect_n && !sr2_reg[SR2_QE];
  wire logic       hw_locked = (lock == 2'b01) && wp_low;
  // Modes 10 and 11 never allow a write; 00 needs only the latch
  wire logic       sr_write_ok = write_enable_latch && ((lock == 2'b00) ||
                                         ((lock == 2'b01) && !wp_low));
  wire logic       whole_ok  = ((bp[2:0] == 3'h0) && !invert) ||
                               ((bp[2:0] == 3'h7) && invert);
  logic            addr_protected;

  fspu_region_check #(
    .ADDR_W           (ADDR_W)
  ) u_region (
    .i_block_protect  (bp),
    .i_protect_invert (invert),
    .i_addr           (i_cmd_addr),
    .o_protected      (addr_protected)
  );

  // Per-kind permission for commands that change array or registers
  wire logic kind_ok =
    is_status_write(cmd)               ? sr_write_ok :
    (cmd == FSPU_CMD_WHOLE_ARRAY_WIPE) ? whole_ok    : !addr_protected;

  // Acceptance of each class; busy blocks everything but suspend and reset
  wire logic acc_modify  = i_cmd_valid && is_modify(cmd) && idle && write_enable_latch && kind_ok;
  wire logic acc_latch   = i_cmd_valid && !busy &&
                           (cmd inside {FSPU_CMD_LATCH_SET, FSPU_CMD_LATCH_CLEAR});
  wire logic acc_suspend = i_cmd_valid && (cmd == FSPU_CMD_OP_SUSPEND) && busy &&
                           !i_op_done && (kind_reg != FSPU_OP_STATUS);
  wire logic acc_resume  = i_cmd_valid && (cmd == FSPU_CMD_OP_RESUME) && suspended;
  wire logic acc_reset   = i_cmd_valid && (cmd == FSPU_CMD_SOFT_RESET);
  wire logic acc_any     = acc_modify || acc_latch || acc_suspend || acc_resume ||
                           acc_reset;
  wire logic finish      = busy && i_op_done;

  // Merged register images for a status write; security lock bits only ever rise
  wire logic [7:0] sr1_wr = (sr1_reg & ~SR1_WR_MASK) | (i_cmd_data[7:0] & SR1_WR_MASK);
  wire logic [7:0] sr2_wr = (sr2_reg & ~SR2_WR_MASK) | (i_cmd_data[15:8] & SR2_WR_MASK)
                            | (i_cmd_data[15:8] & SR2_OTP_MASK);
  wire logic [7:0] sr3_wr = i_cmd_data[7:0] & SR3_WR_MASK;

  // ========================================================================
  // Next-state logic for registers and sequencing
  always_comb
  begin
    sr1_next   = sr1_reg;
    sr2_next   = sr2_reg;
    sr3_next   = sr3_reg;
    state_next = state_reg;
    kind_next  = kind_reg;
    if (finish)
    begin
      state_next = FSPU_ST_IDLE;
    end
    if (acc_reset)
    begin
      // Soft reset drops volatile bits, keeps the stored ones
      sr1_next[SR1_WEL]      = 1'b0;
      sr2_next[SR2_ERASE_SUS] = 1'b0;
      sr2_next[SR2_PROG_SUS]  = 1'b0;
      state_next             = FSPU_ST_IDLE;
    end
    else if (acc_latch)
    begin
      sr1_next[SR1_WEL] = (cmd == FSPU_CMD_LATCH_SET);
    end
    else if (acc_modify)
    begin
      // Only status writes reach the protect and lock bits
      if (cmd == FSPU_CMD_STATUS_WRITE_12)
      begin
        sr1_next = sr1_wr;
        sr2_next = sr2_wr;
      end
      else if (cmd == FSPU_CMD_STATUS_WRITE_3)
      begin
        sr3_next = sr3_wr;
      end
      sr1_next[SR1_WEL] = 1'b0;
      state_next        = FSPU_ST_BUSY;
      kind_next         = is_status_write(cmd) ? FSPU_OP_STATUS :
                          (cmd == FSPU_CMD_PAGE_PROGRAM) ? FSPU_OP_PROGRAM : FSPU_OP_ERASE;
    end
    else if (acc_suspend)
    begin
      sr2_next[SR2_ERASE_SUS] = (kind_reg == FSPU_OP_ERASE);
      sr2_next[SR2_PROG_SUS]  = (kind_reg == FSPU_OP_PROGRAM);
      state_next              = FSPU_ST_SUSPENDED;
    end
    else if (acc_resume)
    begin
      sr2_next[SR2_ERASE_SUS] = 1'b0;
      sr2_next[SR2_PROG_SUS]  = 1'b0;
      state_next              = FSPU_ST_BUSY;
    end
    // Busy flag mirrors the sequencer, read-only to the host
    sr1_next[SR1_WIP] = (state_next == FSPU_ST_BUSY);
  end

  // ========================================================================
  // Registers; power-up reset restores every bit, lock mode 10 included
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      sr1_reg   <= SR1_RESET;
      sr2_reg   <= SR2_RESET;
      sr3_reg   <= SR3_RESET;
      state_reg <= FSPU_ST_IDLE;
      kind_reg  <= FSPU_OP_STATUS;
    end
    else
    begin
      sr1_reg   <= sr1_next;
      sr2_reg   <= sr2_next;
      sr3_reg   <= sr3_next;
      state_reg <= state_next;
      kind_reg  <= kind_next;
    end
  end

  // Answer pulses, one cycle after the command
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      accepted_reg <= 1'b0;
      refused_reg  <= 1'b0;
      start_reg    <= 1'b0;
      suspend_reg  <= 1'b0;
      resume_reg   <= 1'b0;
      abort_reg    <= 1'b0;
      addr_reg     <= '0;
    end
    else
    begin
      accepted_reg <= acc_any;
      refused_reg  <= i_cmd_valid && !acc_any;
      start_reg    <= acc_modify;
      suspend_reg  <= acc_suspend;
      resume_reg   <= acc_resume;
      abort_reg    <= acc_reset && !idle && !finish;
      addr_reg     <= acc_modify ? i_cmd_addr : addr_reg;
    end
  end

  // Outputs straight from flops
  assign o_status_low   = sr1_reg;
  assign o_status_mid   = sr2_reg;
  assign o_status_high  = sr3_reg;
  assign o_cmd_accepted = accepted_reg;
  assign o_cmd_refused  = refused_reg;
  assign o_op_start     = start_reg;
  assign o_op_kind      = kind_reg;
  assign o_op_addr      = addr_reg;
  assign o_op_suspend   = suspend_reg;
  assign o_op_resume    = resume_reg;
  assign o_op_abort     = abort_reg;
  assign o_quad_pins    = sr2_reg[SR2_QE];

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  sequence s_modify_taken;
    acc_modify;
  endsequence

  sequence s_latched_busy;
    !sr1_reg[SR1_WEL] && sr1_reg[SR1_WIP] && o_op_start;
  endsequence

  property p_wip_state;
    sr1_reg[SR1_WIP] == (state_reg == FSPU_ST_BUSY);
  endproperty
  a_wip_state: assert property (p_wip_state) else $error("busy flag wrong");

  property p_no_latch_refuse;
    i_cmd_valid && is_modify(cmd) && !write_enable_latch |=> o_cmd_refused && !o_op_start;
  endproperty
  a_no_latch_refuse: assert property (p_no_latch_refuse) else $error("write without latch");

  property p_modify_seq;
    s_modify_taken |=> s_latched_busy;
  endproperty
  a_modify_seq: assert property (p_modify_seq) else $error("latch or busy wrong");

  property p_hw_hold;
    hw_locked && i_cmd_valid && is_status_write(cmd) && !acc_reset
      |=> $stable(sr1_reg[SR1_LOCK0:SR1_BP_LO]) && $stable(sr2_reg[SR2_LOCK1]);
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("protect bits changed");

  property p_lock_modes;
    i_cmd_valid && is_status_write(cmd) && lock[1] |=> o_cmd_refused;
  endproperty
  a_lock_modes: assert property (p_lock_modes) else $error("locked write taken");

  property p_otp_sticky;
    ##1 ($past(sr2_reg[SR2_LB_HI:SR2_LB_LO]) & ~sr2_reg[SR2_LB_HI:SR2_LB_LO]) == 3'h0;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky) else $error("lock bit fell");

  property p_area_refuse;
    i_cmd_valid && addr_protected &&
      (cmd inside {FSPU_CMD_PAGE_PROGRAM, FSPU_CMD_FOUR_KB_WIPE, FSPU_CMD_BLOCK_WIPE})
      |=> o_cmd_refused && !o_op_start;
  endproperty
  a_area_refuse: assert property (p_area_refuse) else $error("protected area hit");

  property p_whole_refuse;
    i_cmd_valid && (cmd == FSPU_CMD_WHOLE_ARRAY_WIPE) && !whole_ok |=> o_cmd_refused;
  endproperty
  a_whole_refuse: assert property (p_whole_refuse) else $error("array wipe taken");

  property p_suspend_flags;
    acc_suspend |=> (sr2_reg[SR2_ERASE_SUS] ^ sr2_reg[SR2_PROG_SUS]) && !sr1_reg[SR1_WIP]
      ##1 o_op_kind == $past(o_op_kind);
  endproperty
  a_suspend_flags: assert property (p_suspend_flags) else $error("suspend flags wrong");

  property p_reserved_zero;
    sr3_reg[SR3_RSV_HI:SR3_RSV_LO] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // ========================================================================
  // Command answers, latch and volatile flags
  // Suspend flags both low after resume or soft reset
  sequence s_flags_clear;
    !sr2_reg[SR2_ERASE_SUS] && !sr2_reg[SR2_PROG_SUS];
  endsequence

  property p_answer_once;
    i_cmd_valid |=> o_cmd_accepted != o_cmd_refused;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("no single answer");

  property p_latch_set;
    acc_latch && (cmd == FSPU_CMD_LATCH_SET) |=> sr1_reg[SR1_WEL] && o_cmd_accepted;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_sr_write_open;
    i_cmd_valid && is_status_write(cmd) && idle && write_enable_latch && (lock == 2'b00)
      |=> o_cmd_accepted && o_op_start;
  endproperty
  a_sr_write_open: assert property (p_sr_write_open) else $error("open write refused");

  // Any other command leaving lock0 or the protect bits moved is a leak
  property p_bp_by_write;
    !(i_cmd_valid && is_status_write(cmd)) |=> $stable(sr1_reg[SR1_LOCK0:SR1_BP_LO]);
  endproperty
  a_bp_by_write: assert property (p_bp_by_write) else $error("protect bits moved");

  property p_resume_clears;
    acc_resume |=> o_op_resume && sr1_reg[SR1_WIP] ##0 s_flags_clear;
  endproperty
  a_resume_clears: assert property (p_resume_clears) else $error("resume flags wrong");

  property p_soft_reset;
    acc_reset |=> !sr1_reg[SR1_WEL] && !sr1_reg[SR1_WIP] ##0 s_flags_clear;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left flags");

endmodule // fspu_status_protect

// *** hdl/fspu_pkg.sv ***
// ==========================================================================
// Shared constants for the flash status and protection unit
package fspu_pkg;

  // ========================================================================
  // Command, operation and state encodings
  typedef enum logic [3:0] {
    FSPU_CMD_LATCH_SET,
    FSPU_CMD_LATCH_CLEAR,
    FSPU_CMD_STATUS_WRITE_12,
    FSPU_CMD_STATUS_WRITE_3,
    FSPU_CMD_PAGE_PROGRAM,
    FSPU_CMD_FOUR_KB_WIPE,
    FSPU_CMD_BLOCK_WIPE,
    FSPU_CMD_WHOLE_ARRAY_WIPE,
    FSPU_CMD_OP_SUSPEND,
    FSPU_CMD_OP_RESUME,
    FSPU_CMD_SOFT_RESET
  } fspu_cmd_t;

  typedef enum logic [1:0] {
    FSPU_OP_STATUS,
    FSPU_OP_PROGRAM,
    FSPU_OP_ERASE
  } fspu_op_t;

  typedef enum logic [1:0] {
    FSPU_ST_IDLE,
    FSPU_ST_BUSY,
    FSPU_ST_SUSPENDED
  } fspu_state_t;

  // ========================================================================
  // Bit positions inside each 8-bit status register
  localparam int SR1_LOCK0     = 7;
  localparam int SR1_BP_HI     = 6;
  localparam int SR1_BP_LO     = 2;
  localparam int SR1_WEL       = 1;
  localparam int SR1_WIP       = 0;
  localparam int SR2_ERASE_SUS = 7;
  localparam int SR2_INVERT    = 6;
  localparam int SR2_LB_HI     = 5;
  localparam int SR2_LB_LO     = 3;
  localparam int SR2_PROG_SUS  = 2;
  localparam int SR2_QE        = 1;
  localparam int SR2_LOCK1     = 0;
  localparam int SR3_RSV_HI    = 4;
  localparam int SR3_RSV_LO    = 2;

  // ========================================================================
  // Write masks and values after power-up
  localparam logic [7:0] SR1_WR_MASK  = 8'hFC;
  localparam logic [7:0] SR2_WR_MASK  = 8'h43;
  localparam logic [7:0] SR2_OTP_MASK = 8'h38;
  localparam logic [7:0] SR3_WR_MASK  = 8'hE3;
  localparam logic [7:0] SR1_RESET    = 8'h00;
  localparam logic [7:0] SR2_RESET    = 8'h00;
  localparam logic [7:0] SR3_RESET    = 8'h20;

  // ========================================================================
  // Protected-region sizing: log2 of each unit size in bytes, and the small-unit step cap
  localparam logic [4:0] SMALL_UNIT_LOG2 = 5'h0C;
  localparam logic [4:0] LARGE_UNIT_LOG2 = 5'h12;
  localparam logic [2:0] SMALL_MAX_STEP  = 3'h3;

endpackage

// *** hdl/fspu_region_check.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Address-against-protect-code decoder, purely combinational
module fspu_region_check
  import fspu_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  input  wire logic [4:0]        i_block_protect,
  input  wire logic              i_protect_invert,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic                   o_protected
);

  // Low three bits pick the size, bit 3 the end, bit 4 the unit
  wire logic [2:0]        code     = i_block_protect[2:0];
  wire logic              sel_none = (code == 3'h0);
  wire logic              sel_all  = (code == 3'h7);
  wire logic [2:0]        raw_step = code - 3'h1;
  // Small units stop growing at 32KB
  wire logic [2:0]        step     = (i_block_protect[4] && raw_step > SMALL_MAX_STEP) ?
                                     SMALL_MAX_STEP : raw_step;
  wire logic [4:0]        size_log = (i_block_protect[4] ? SMALL_UNIT_LOG2 : LARGE_UNIT_LOG2)
                                     + {2'h0, step};
  wire logic [ADDR_W-1:0] hi_mask  = {ADDR_W{1'b1}} << size_log;

  // Bottom region: high bits all zero; top region: high bits all one
  wire logic lower_hit = ((i_addr & hi_mask) == '0);
  wire logic upper_hit = ((~i_addr & hi_mask) == '0);
  wire logic hit       = i_block_protect[3] ? lower_hit : upper_hit;
  wire logic plain     = sel_none ? 1'b0 : (sel_all ? 1'b1 : hit);

  // Complement flips the whole map
  assign o_protected = plain ^ i_protect_invert;

endmodule // fspu_region_check

// *** verif/fspu_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Host controller and array engine stand-in for the status unit
module fspu_host_model
  import fspu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_busy,
  input  wire logic        i_cmd_accepted,
  input  wire logic        i_op_abort,
  output logic             o_cmd_valid,
  output logic [3:0]       o_cmd_code,
  output logic [23:0]      o_cmd_addr,
  output logic [15:0]      o_cmd_data,
  output logic             o_op_done
);
  int done_delay = 3;
  int busy_count = 0;

  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 4'h0;
    o_cmd_addr  = 24'h00_0000;
    o_cmd_data  = 16'h0000;
    o_op_done   = 1'b0;
  end

  // Engine counts only while busy, so a suspended job keeps its progress;
  // an abort drops it, else the next job would finish early
  always @(posedge i_clock)
  begin
    o_op_done <= 1'b0;
    if (i_op_abort)
    begin
      busy_count <= 0;
    end
    else if (i_busy && !o_op_done)
    begin
      busy_count <= busy_count + 1;
      if (busy_count + 1 >= done_delay)
      begin
        o_op_done  <= 1'b1;
        busy_count <= 0;
      end
    end
  end

  // One-cycle strobe; the answer is taken at the edge after the strobe
  task automatic issue(input fspu_cmd_t c, input logic [23:0] a, input logic [15:0] d,
                       output logic ok);
    @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd_code  <= c;
    o_cmd_addr  <= a;
    o_cmd_data  <= d;
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    #1;
    ok = i_cmd_accepted;
  endtask
endmodule // fspu_host_model

// *** verif/fspu_status_protect_test.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the status and protection unit
module fspu_status_protect_test
  import fspu_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_write_protect_n = 1'b1;
  logic        cmd_valid, op_done, accepted, quad, op_start;
  logic        refused, op_susp, op_res, op_abort;
  logic [1:0]  op_kind;
  logic [3:0]  cmd_code;
  logic [23:0] cmd_addr, op_addr;
  logic [15:0] cmd_data;
  logic [7:0]  st_low, st_mid, st_high;
  int          num_errors = 0;
  int          checks = 0;

  initial
  begin
    forever #2 i_clock = ~i_clock;
  end

  fspu_host_model u_fspu_host_model (.i_clock(i_clock), .i_busy(st_low[0]),
    .i_cmd_accepted(accepted), .i_op_abort(op_abort), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code),
    .o_cmd_addr(cmd_addr), .o_cmd_data(cmd_data), .o_op_done(op_done));

  fspu_status_protect u_fspu_status_protect (.i_clock(i_clock), .i_srst(i_srst),
    .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_addr(cmd_addr),
    .i_cmd_data(cmd_data), .i_write_protect_n(i_write_protect_n), .i_op_done(op_done),
    .o_status_low(st_low), .o_status_mid(st_mid), .o_status_high(st_high),
    .o_cmd_accepted(accepted), .o_cmd_refused(refused), .o_op_start(op_start),
    .o_op_kind(op_kind), .o_op_addr(op_addr), .o_op_suspend(op_susp),
    .o_op_resume(op_res), .o_op_abort(op_abort),
    .o_quad_pins(quad));

  // ========================================================================
  // Shared helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input fspu_cmd_t c, input logic [23:0] a, input logic [15:0] d,
                     input logic exp_ok);
    logic ok;
    u_fspu_host_model.issue(c, a, d, ok);
    chk(c.name(), 24'(exp_ok), 24'(ok));
    chk("refused", 24'(!exp_ok), 24'(refused));
  endtask

  // Bounded wait for the engine to finish
  task automatic wait_idle();
    for (int n = 0; n < 100 && st_low[0] !== 1'b0; n++) @(posedge i_clock);
    #1;
    chk("busy", 24'h0, 24'(st_low[0]));
  endtask

  task automatic status_write(input logic [15:0] d);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, d, 1'b1);
    wait_idle();
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_srst <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_latch();
    chk("bytes", 24'h20_0000, {st_high, st_mid, st_low});
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'h0004, 1'b0);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    chk("latch", 24'h02, 24'(st_low));
    cmd(FSPU_CMD_LATCH_CLEAR, 24'h0, 16'h0, 1'b1);
    chk("latch", 24'h00, 24'(st_low));
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'h0, 16'h0, 1'b0);
  endtask

  task automatic t_busy_protect();
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    // Lock1 left clear, or mode 10 would lock out status writes until the next power-up reset
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'hFE04, 1'b1);
    chk("low busy", 24'h05, 24'(st_low));
    chk("mid ro", 24'h7A, 24'(st_mid));
    chk("op kind", 24'(FSPU_OP_STATUS), 24'(op_kind));
    wait_idle();
    status_write(16'h0004);
    chk("mid otp", 24'h38, 24'(st_mid));
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'hFC_0000, 16'h0, 1'b0);
    cmd(FSPU_CMD_WHOLE_ARRAY_WIPE, 24'h0, 16'h0, 1'b0);
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'hFB_FFFF, 16'h0, 1'b1);
    chk("op addr", 24'hFB_FFFF, op_addr);
    chk("op start", 24'h1, 24'(op_start));
    chk("op kind", 24'(FSPU_OP_PROGRAM), 24'(op_kind));
    wait_idle();
  endtask

  task automatic t_invert();
    status_write(16'h4004);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_FOUR_KB_WIPE, 24'h00_0000, 16'h0, 1'b0);
    cmd(FSPU_CMD_BLOCK_WIPE, 24'hFC_0000, 16'h0, 1'b1);
    wait_idle();
    status_write(16'h4044);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'hFF_EFFF, 16'h0, 1'b0);
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'hFF_F000, 16'h0, 1'b1);
    wait_idle();
    status_write(16'h401C);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_WHOLE_ARRAY_WIPE, 24'h0, 16'h0, 1'b1);
    wait_idle();
  endtask

  task automatic t_pin();
    status_write(16'h0080);
    @(posedge i_clock) i_write_protect_n <= 1'b0;
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'h0004, 1'b0);
    chk("low held", 24'h82, 24'(st_low));
    @(posedge i_clock) i_write_protect_n <= 1'b1;
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'h0284, 1'b1);
    wait_idle();
    chk("quad", 24'h1, 24'(quad));
    @(posedge i_clock) i_write_protect_n <= 1'b0;
    status_write(16'h0000);
    chk("low", 24'h00, 24'(st_low));
    @(posedge i_clock) i_write_protect_n <= 1'b1;
  endtask

  task automatic t_suspend();
    u_fspu_host_model.done_delay = 40;
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_PAGE_PROGRAM, 24'h00_0100, 16'h0, 1'b1);
    cmd(FSPU_CMD_OP_SUSPEND, 24'h0, 16'h0, 1'b1);
    chk("prog susp", 24'h3C_00, 24'({st_mid, st_low}));
    chk("susp pulse", 24'h1, 24'(op_susp));
    cmd(FSPU_CMD_OP_RESUME, 24'h0, 16'h0, 1'b1);
    chk("resumed", 24'h38_01, 24'({st_mid, st_low}));
    chk("resume pulse", 24'h1, 24'(op_res));
    wait_idle();
    cmd(FSPU_CMD_OP_RESUME, 24'h0, 16'h0, 1'b0);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_FOUR_KB_WIPE, 24'h00_0000, 16'h0, 1'b1);
    cmd(FSPU_CMD_OP_SUSPEND, 24'h0, 16'h0, 1'b1);
    chk("erase susp", 24'hB8, 24'(st_mid));
    chk("erase kind", 24'(FSPU_OP_ERASE), 24'(op_kind));
    cmd(FSPU_CMD_SOFT_RESET, 24'h0, 16'h0, 1'b1);
    chk("soft reset", 24'h38_00, 24'({st_mid, st_low}));
    chk("abort", 24'h1, 24'(op_abort));
    u_fspu_host_model.done_delay = 3;
  endtask

  task automatic t_high_lock();
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_STATUS_WRITE_3, 24'h0, 16'h00FF, 1'b1);
    wait_idle();
    chk("high", 24'hE3, 24'(st_high));
    status_write(16'h0100);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'h0000, 1'b0);
    do_reset();
    chk("power up", 24'h20_0000, {st_high, st_mid, st_low});
    status_write(16'h0180);
    cmd(FSPU_CMD_LATCH_SET, 24'h0, 16'h0, 1'b1);
    cmd(FSPU_CMD_STATUS_WRITE_12, 24'h0, 16'h0000, 1'b0);
  endtask

  // ========================================================================
  // Main sequence and watchdog, sized well beyond the expected run
  initial
  begin
    do_reset();
    t_latch();
    t_busy_protect();
    t_invert();
    t_pin();
    t_suspend();
    t_high_lock();
    summarize();
  end

  initial
  begin
    #40000;
    num_errors++;
    summarize();
  end
endmodule // fspu_status_protect_test
